// ### rtl/icd_pkg.sv
// constants, register map and carrier types of the intercore doorbell unit
// assumes one system clock and a synchronous active-high unit reset
//
// Summary of operation
// - four independent doorbell channels, each with request, pending and enable bits
// - side B writing one to request bit n sets side A pending bit n
// - side A interrupt n fires while its pending n and enable n are both one
// - side B request n clears itself when side A clears pending n by writing one
// - side B writing zero cannot force side A pending bits low
// - unit reset clears every request bit
// - enable bits 31 to 28 of side B control raise side B interrupt on pending
// - with enable n zero, pending n is ignored and no interrupt n issues
// - unit reset clears every interrupt enable bit
// - pending n clears only on a write of one while set; other writes ignored
// - unit reset clears every pending bit
`default_nettype none
package icd_pkg;

  localparam int unsigned ICD_CHANNELS = 4;

  // byte offsets, one aligned word each
  localparam logic [3:0] ICD_OFS_A_CONTROL = 4'h0;
  localparam logic [3:0] ICD_OFS_A_STATUS  = 4'h4;
  localparam logic [3:0] ICD_OFS_B_CONTROL = 4'h8;
  localparam logic [3:0] ICD_OFS_B_STATUS  = 4'hc;

  // field positions, shared by control and status words
  localparam int unsigned ICD_REQ_LSB = 16;
  localparam int unsigned ICD_ENA_LSB = 28;
  localparam int unsigned ICD_PND_LSB = 28;

  localparam logic [3:0] ICD_RST_BITS = 4'h0;

  typedef logic [ICD_CHANNELS-1:0] icd_bits_t;

  typedef struct packed {
    icd_bits_t request;
    icd_bits_t enable;
    icd_bits_t pending;
  } icd_side_s;

  typedef enum logic [1:0] {
    ICD_IDLE = 2'b00,
    ICD_ACK  = 2'b01
  } icd_bus_e;

endpackage
`default_nettype wire

// ### rtl/icd_side.sv
// one side of the doorbell: enable and request bits, the pending bits it owns
// assumes the parent decodes the bus; strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module icd_side
  import icd_pkg::*;
(
  // clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // own control write
  input  wire logic      ctl_we_i,
  input  wire icd_bits_t ctl_req_i,
  input  wire icd_bits_t ctl_ena_i,
  // own status write-one-to-clear
  input  wire logic      sts_we_i,
  input  wire icd_bits_t sts_clr_i,
  // from far side
  input  wire icd_bits_t far_set_i,
  input  wire icd_bits_t far_clr_i,
  // state and interrupt
  output var  icd_side_s state_o,
  output var  icd_bits_t own_clr_o,
  output logic           irq_o
);

  icd_side_s st_reg;
  icd_side_s st_next;
  icd_bits_t clr_now;

  always_comb
  begin
    st_next = st_reg;
    // a clear only counts for a bit that is set
    clr_now = sts_we_i ? (sts_clr_i & st_reg.pending) : ICD_RST_BITS;
    if (ctl_we_i)
    begin
      st_next.enable  = ctl_ena_i;
      // writing zero never drops a request; only the far clear does
      st_next.request = st_reg.request | ctl_req_i;
    end
    st_next.request = st_next.request & ~far_clr_i;
    // a set in the same cycle as a clear wins
    st_next.pending = (st_reg.pending & ~clr_now) | far_set_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg.request <= ICD_RST_BITS;
      st_reg.enable  <= ICD_RST_BITS;
      st_reg.pending <= ICD_RST_BITS;
    end
    else
      st_reg <= st_next;
  end

  assign state_o   = st_reg;
  assign own_clr_o = clr_now;
  assign irq_o     = |(st_reg.pending & st_reg.enable);

  chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctl_we_i && (far_set_i & st_reg.enable) != 0) |=> irq_o) else $error("irq not raised on enabled set");
  chk_clr_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (sts_we_i && (sts_clr_i & st_reg.pending) != 0 && far_set_i == 0)
    |=> (st_reg.pending & $past(sts_clr_i & st_reg.pending)) == 0) else $error("pending not cleared");
  chk_zero_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (!sts_we_i && !rst_i) |=> (st_reg.pending & $past(st_reg.pending)) == $past(st_reg.pending))
    else $error("pending dropped without clear");

endmodule
`default_nettype wire

// ### rtl/icd_top.sv
// top of the intercore doorbell: classic wishbone slave, two sides, interrupts
// assumes a classic single-cycle wishbone master on the system clock
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module icd_top
  import icd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // interrupts toward each core
  output logic             irq_a_o,
  output logic             irq_b_o
);

  typedef struct packed {
    icd_bus_e    bus;
    logic [31:0] rdata;
  } icd_top_s;

  icd_top_s  top_reg;
  icd_top_s  top_next;
  icd_side_s st_a;
  icd_side_s st_b;
  icd_bits_t clr_a;
  icd_bits_t clr_b;
  logic      wr;
  logic      we_actl;
  logic      we_asts;
  logic      we_bctl;
  logic      we_bsts;
  logic      hi_lanes;

  function automatic logic [31:0] ctl_word(input icd_side_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ICD_ENA_LSB +: ICD_CHANNELS] = s.enable;
    w[ICD_REQ_LSB +: ICD_CHANNELS] = s.request;
    return w;
  endfunction

  function automatic logic [31:0] sts_word(input icd_side_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ICD_PND_LSB +: ICD_CHANNELS] = s.pending;
    return w;
  endfunction

  // write strobe only in the answer-free cycle; fields sit in the top two lanes
  assign wr       = cyc_i && stb_i && we_i && (top_reg.bus == ICD_IDLE);
  assign hi_lanes = sel_i[3] && sel_i[2];
  assign we_actl  = wr && hi_lanes && (adr_i == ICD_OFS_A_CONTROL);
  assign we_asts  = wr && sel_i[3] && (adr_i == ICD_OFS_A_STATUS);
  assign we_bctl  = wr && hi_lanes && (adr_i == ICD_OFS_B_CONTROL);
  assign we_bsts  = wr && sel_i[3] && (adr_i == ICD_OFS_B_STATUS);

  // side A: its requests feed B pending; B's clears release them
  icd_side u_side_a (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ctl_we_i  (we_actl),
    .ctl_req_i (dat_i[ICD_REQ_LSB +: ICD_CHANNELS]),
    .ctl_ena_i (dat_i[ICD_ENA_LSB +: ICD_CHANNELS]),
    .sts_we_i  (we_asts),
    .sts_clr_i (dat_i[ICD_PND_LSB +: ICD_CHANNELS]),
    .far_set_i (we_bctl ? dat_i[ICD_REQ_LSB +: ICD_CHANNELS] : ICD_RST_BITS),
    .far_clr_i (clr_b),
    .state_o   (st_a),
    .own_clr_o (clr_a),
    .irq_o     (irq_a_o)
  );

  icd_side u_side_b (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ctl_we_i  (we_bctl),
    .ctl_req_i (dat_i[ICD_REQ_LSB +: ICD_CHANNELS]),
    .ctl_ena_i (dat_i[ICD_ENA_LSB +: ICD_CHANNELS]),
    .sts_we_i  (we_bsts),
    .sts_clr_i (dat_i[ICD_PND_LSB +: ICD_CHANNELS]),
    .far_set_i (we_actl ? dat_i[ICD_REQ_LSB +: ICD_CHANNELS] : ICD_RST_BITS),
    .far_clr_i (clr_a),
    .state_o   (st_b),
    .own_clr_o (clr_b),
    .irq_o     (irq_b_o)
  );

  always_comb
  begin
    top_next = top_reg;
    case (top_reg.bus)
      ICD_IDLE:
      begin
        if (cyc_i && stb_i)
        begin
          top_next.bus = ICD_ACK;
          case (adr_i)
            ICD_OFS_A_CONTROL: top_next.rdata = ctl_word(st_a);
            ICD_OFS_A_STATUS:  top_next.rdata = sts_word(st_a);
            ICD_OFS_B_CONTROL: top_next.rdata = ctl_word(st_b);
            ICD_OFS_B_STATUS:  top_next.rdata = sts_word(st_b);
            default:           top_next.rdata = 32'h0000_0000;
          endcase
        end
      end
      ICD_ACK:
        top_next.bus = ICD_IDLE;
      default:
        top_next.bus = ICD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      top_reg.bus   <= ICD_IDLE;
      top_reg.rdata <= 32'h0000_0000;
    end
    else
      top_reg <= top_next;
  end

  assign ack_o = (top_reg.bus == ICD_ACK);
  assign dat_o = top_reg.rdata;

  chk_req_sets_pnd: assert property (@(posedge clk_i) disable iff (rst_i)
    (we_bctl && dat_i[ICD_REQ_LSB]) |=> st_a.pending[0]) else $error("B request missed A pending");
  chk_req_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (we_asts && dat_i[ICD_PND_LSB] && st_a.pending[0] && !we_bctl) |=> !st_b.request[0])
    else $error("B request not released");
  chk_b_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (we_actl && (dat_i[ICD_REQ_LSB +: ICD_CHANNELS] & st_b.enable) != 0) |=> irq_b_o)
    else $error("B irq missing");
  chk_no_ena: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_a.enable == 0) |-> !irq_a_o) else $error("A irq without enable");
  chk_reset_clr: assert property (@(posedge clk_i)
    rst_i |=> (st_a == '0 && st_b == '0)) else $error("reset left bits set");
  chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held");

  cov_b_rings: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_a_o));
  cov_a_rings: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_b_o));
  cov_release: cover property (@(posedge clk_i) disable iff (rst_i) $fell(st_b.request[0]));

endmodule
`default_nettype wire

// ### dv/icd_core_model.sv
// wishbone master model of the two cores sharing the doorbell bus
// assumes a classic single-cycle slave on the system clock
`timescale 1ns/1ps
`default_nettype none
module icd_core_model
  import icd_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // wishbone master
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o = 1'b0,
  output logic             stb_o = 1'b0,
  output logic             we_o  = 1'b0,
  output logic [3:0]       adr_o = 4'h0,
  output logic [3:0]       sel_o = 4'hf,
  output logic [31:0]      dat_o = 32'h0000_0000,
  // wait ran out
  output logic             tmo_o = 1'b0
);
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q,
                      input logic [3:0] s);
    int k;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_i !== 1'b1 && k < 64);
    q = dat_i;
    tmo_o <= (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released lines show inverted junk, not the last value
    we_o  <= ~w;
    adr_o <= ~a;
    sel_o <= ~s;
    dat_o <= ~d;
  endtask

  // raise request n only once the previous one was taken; enables kept
  task automatic ring(input logic [3:0] ctl, input int n);
    logic [31:0] q;
    xfer(1'b0, ctl, 32'h0000_0000, q, 4'hf);
    if (q[ICD_REQ_LSB+n] === 1'b0)
      xfer(1'b1, ctl, (q & 32'hf000_0000) | (32'h1 << (ICD_REQ_LSB + n)), q, 4'hf);
  endtask
endmodule
`default_nettype wire

// ### dv/tb_icd_top.sv
// self-checking bench of the doorbell unit through its wishbone port
// assumes the core model as the only bus master
`timescale 1ns/1ps
`default_nettype none
module tb_icd_top;
  import icd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, irq_a, irq_b, tmo;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, q, e;
  int          mismatches = 0;
  int          n_compared = 0;

  always #5 clk_i = ~clk_i;

  icd_top icd_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_a_o(irq_a), .irq_b_o(irq_b));
  icd_core_model icd_core_model_i (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .tmo_o(tmo));

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    icd_core_model_i.xfer(1'b0, a, 32'h0000_0000, q, 4'hf);
    chk(q, x);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    icd_core_model_i.xfer(1'b1, a, d, q, 4'hf);
  endtask
  task automatic all_clear();
    for (int i = 0; i < 4; i++)
      rd({i[1:0], 2'b00}, 32'h0000_0000);
    chk({30'h0, irq_a, irq_b}, 32'h0000_0000);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge tmo)
  begin
    mismatches++;
    results();
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    all_clear();
    wr(4'h6, 32'hffff_ffff);
    rd(4'h6, 32'h0000_0000);
    // control write missing a high lane must not land anywhere
    icd_core_model_i.xfer(1'b1, ICD_OFS_A_CONTROL, 32'hffff_ffff, q, 4'hb);
    all_clear();
    $display("test reset and unmapped done");
    e = 32'h0000_0000;
    for (int n = 0; n < 4; n++)
    begin
      icd_core_model_i.ring(ICD_OFS_B_CONTROL, n);
      e |= 32'h1 << (ICD_PND_LSB + n);
      rd(ICD_OFS_A_STATUS, e);
      chk({31'h0, irq_a}, 32'h0000_0000);
    end
    wr(ICD_OFS_B_CONTROL, 32'h0000_0000);
    rd(ICD_OFS_A_STATUS, 32'hf000_0000);
    rd(ICD_OFS_B_CONTROL, 32'h000f_0000);
    wr(ICD_OFS_A_CONTROL, 32'h1000_0000);
    chk({31'h0, irq_a}, 32'h0000_0001);
    wr(ICD_OFS_A_STATUS, 32'he000_0000);
    rd(ICD_OFS_B_CONTROL, 32'h0001_0000);
    chk({31'h0, irq_a}, 32'h0000_0001);
    wr(ICD_OFS_A_STATUS, 32'h0000_0000);
    icd_core_model_i.xfer(1'b1, ICD_OFS_A_STATUS, 32'h1000_0000, q, 4'h7);
    rd(ICD_OFS_A_STATUS, 32'h1000_0000);
    wr(ICD_OFS_A_STATUS, 32'h1000_0000);
    chk({31'h0, irq_a}, 32'h0000_0000);
    rd(ICD_OFS_B_CONTROL, 32'h0000_0000);
    wr(ICD_OFS_A_STATUS, 32'h1000_0000);
    rd(ICD_OFS_A_STATUS, 32'h0000_0000);
    $display("test side b doorbell done");
    icd_core_model_i.ring(ICD_OFS_A_CONTROL, 2);
    rd(ICD_OFS_B_STATUS, 32'h4000_0000);
    chk({31'h0, irq_b}, 32'h0000_0000);
    wr(ICD_OFS_B_CONTROL, 32'h4000_0000);
    chk({31'h0, irq_b}, 32'h0000_0001);
    wr(ICD_OFS_B_STATUS, 32'h4000_0000);
    chk({31'h0, irq_b}, 32'h0000_0000);
    rd(ICD_OFS_A_CONTROL, 32'h1000_0000);
    // ring into an already enabled channel; left pending for the reset test
    icd_core_model_i.ring(ICD_OFS_A_CONTROL, 2);
    chk({31'h0, irq_b}, 32'h0000_0001);
    $display("test side a doorbell done");
    icd_core_model_i.ring(ICD_OFS_B_CONTROL, 3);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    all_clear();
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
